// file: logic/ffsb_pkg.sv
// ffsb_pkg: register map, flag bit positions and carrier types for the flag bank
// assumes a single clock domain and an 8-bit register port
package ffsb_pkg;

    localparam int          FFSB_AW        = 4;
    localparam int          FFSB_DW        = 8;
    localparam int          FFSB_NREG      = 4;

    // live flags at 0x0..0x3, latched copies at 0x4..0x7, selected latch clear at 0x8, keyed clear of all latches at 0x9
    localparam logic [3:0]  ADDR_LIVE0     = 4'h0;
    localparam logic [3:0]  ADDR_LIVE1     = 4'h1;
    localparam logic [3:0]  ADDR_LIVE2     = 4'h2;
    localparam logic [3:0]  ADDR_LIVE3     = 4'h3;
    localparam logic [3:0]  ADDR_LATCH0    = 4'h4;
    localparam logic [3:0]  ADDR_LATCH3    = 4'h7;
    localparam logic [3:0]  ADDR_CLR_SEL   = 4'h8;
    localparam logic [3:0]  ADDR_CLR_ALL   = 4'h9;

    localparam logic [7:0]  FLAG_RST       = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;
    // reserved bit 5 of the fourth register
    localparam logic [7:0]  REG3_MASK      = 8'hdf;
    localparam logic [31:0] CLR_ALL_KEY    = 32'h0000_00a5;
    localparam logic [7:0]  CLR_ALL_VAL    = 8'ha5;

    // bit positions
    localparam int B0_SUPPLY_OFF   = 7;
    localparam int B0_ISO_OFF      = 6;
    localparam int B0_PG1_FAULT    = 5;
    localparam int B0_PG2_FAULT    = 4;
    localparam int B0_RECT_OFF     = 3;
    localparam int B0_PRI_FAST_OC  = 2;
    localparam int B0_PRI_ACC_OC   = 1;
    localparam int B0_SEC_ACC_OC   = 0;
    localparam int B1_CONTINUITY   = 7;
    localparam int B1_LOCAL_UV     = 6;
    localparam int B1_ISO_REVERSE  = 5;
    localparam int B1_VDD_UV       = 4;
    localparam int B1_CORE_OV      = 3;
    localparam int B1_VDD_OV       = 2;
    localparam int B1_REMOTE_OV    = 1;
    localparam int B1_LOCAL_OV     = 0;
    localparam int B2_OVER_TEMP    = 7;
    localparam int B2_FAST_OV      = 6;
    localparam int B2_SHARE        = 5;
    localparam int B2_CONST_CURR   = 4;
    localparam int B2_SOFT_START   = 3;
    localparam int B2_LINE_IMP     = 2;
    localparam int B2_SS_FILTER    = 1;
    localparam int B2_EXT_FAULT    = 0;
    localparam int B3_VSB_LIMIT    = 7;
    localparam int B3_MOD_CLAMP    = 6;
    localparam int B3_LIGHT_LOAD   = 4;
    localparam int B3_DEAD_TIME    = 3;
    localparam int B3_AC_SENSE     = 2;
    localparam int B3_NVM_CRC      = 1;
    localparam int B3_NVM_UNLOCK   = 0;

    typedef logic [FFSB_DW-1:0] ffsb_byte_t;

    // raw conditions from the power stage, one bit each, high = condition present
    typedef struct packed {
        logic supply_off;
        logic isolation_switch_gate_off;
        logic power_good_first_fault;
        logic power_good_second_fault;
        logic rectifier_drive_a_off;
        logic rectifier_drive_b_off;
        logic primary_fast_oc;
        logic primary_accurate_oc;
        logic secondary_accurate_oc;
        logic continuity_local_remote_bad;
        logic continuity_remote_pair_bad;
        logic local_undervoltage;
        logic isolation_switch_reverse;
        logic vdd_undervoltage;
        logic core_supply_overvoltage;
        logic vdd_overvoltage;
        logic remote_a_overvoltage;
        logic remote_b_overvoltage;
        logic local_overvoltage;
        logic over_temperature;
        logic fast_overvoltage;
        logic share_out_of_window;
        logic constant_current;
        logic soft_start_ramp;
        logic line_impedance_high;
        logic soft_start_filter;
        logic external_fault_input;
        logic vsb_at_max;
        logic vsb_at_min;
        logic mod_at_upper;
        logic mod_at_lower;
        logic light_load;
        logic dead_time_active;
        logic ac_sense_input_bad;
        logic nvm_crc_fail;
        logic nvm_unlocked;
    } ffsb_cond_s;

    typedef struct packed {
        logic [FFSB_AW-1:0] addr;
        ffsb_byte_t         wdata;
        logic               wr;
        logic               rd;
    } ffsb_bus_s;

endpackage

// file: logic/ffsb_flag_bank.sv
// ffsb_flag_bank: live and latched fault flag registers of the power controller
// assumes conditions synchronous to REF_CLK and a single-cycle strobe register port
// How it works
// (RULE1) reg3 bit7: volt-second balance at limit
// (RULE2) reg3 bit6: modulation clamped high or low
// (RULE3) reg3 bit4: light-load mode active
// (RULE4) reg3 bit3: adaptive dead time moving edges
// (RULE5) reg3 bit2: ac sense amplitude wrong
// (RULE6) reg3 bit1: nonvolatile memory checksum failed
// (RULE7) reg3 bit0: nonvolatile memory unlocked
// (RULE8) reg0 bit7: supply output off
// (RULE9) reg0 bit6: isolation switch gate off
// (RULE10) reg0 bit3: both rectifier drives disabled
// (RULE11) reg0 bit2: primary fast overcurrent
// (RULE12) reg0 bits1,0: primary/secondary accurate overcurrent
// (RULE13) reg1 bit7: sense continuity out of window
// (RULE14) reg1 bit6: local sense undervoltage
// (RULE15) reg1 bit5: isolation switch reverse voltage
// (RULE16) reg1 bit3: core supply overvoltage
// (RULE17) reg1 bits1,0: remote/local sense overvoltage
// (RULE18) reg2 bit7: overtemperature
// (RULE19) reg2 bit5: current share out of window
// (RULE20) reg2 bit3: soft-start reference ramping
// (RULE21) reg2 bit0: external fault input asserted
// (RULE22) latched set mirrors live bit layout
// (RULE23) latched bits sticky until software clears
// (RULE24) reserved reg3 bit5 reads zero
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module ffsb_flag_bank
    import ffsb_pkg::*;
(
    input  wire logic               REF_CLK,
    input  wire logic               RST,
    input  wire ffsb_cond_s         COND,
    input  wire logic [FFSB_AW-1:0] ADDR,
    input  wire ffsb_byte_t         WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic      [FFSB_DW-1:0] RDATA,
    output logic                    ANY_LATCHED
);

    // forms one live byte per register from the raw conditions
    function automatic ffsb_byte_t build_live(input ffsb_cond_s c, input int idx);
        ffsb_byte_t b;
        b = FLAG_RST;
        unique case (idx)
            0: begin
                b[B0_SUPPLY_OFF]  = c.supply_off;                                      // [RULE8]
                b[B0_ISO_OFF]     = c.isolation_switch_gate_off;                       // [RULE9]
                b[B0_PG1_FAULT]   = c.power_good_first_fault;
                b[B0_PG2_FAULT]   = c.power_good_second_fault;
                b[B0_RECT_OFF]    = c.rectifier_drive_a_off & c.rectifier_drive_b_off; // [RULE10]
                b[B0_PRI_FAST_OC] = c.primary_fast_oc;                                 // [RULE11]
                b[B0_PRI_ACC_OC]  = c.primary_accurate_oc;                             // [RULE12]
                b[B0_SEC_ACC_OC]  = c.secondary_accurate_oc;                           // [RULE12]
            end
            1: begin
                b[B1_CONTINUITY]  = c.continuity_local_remote_bad
                                  | c.continuity_remote_pair_bad;                      // [RULE13]
                b[B1_LOCAL_UV]    = c.local_undervoltage;                              // [RULE14]
                b[B1_ISO_REVERSE] = c.isolation_switch_reverse;                        // [RULE15]
                b[B1_VDD_UV]      = c.vdd_undervoltage;
                b[B1_CORE_OV]     = c.core_supply_overvoltage;                         // [RULE16]
                b[B1_VDD_OV]      = c.vdd_overvoltage;
                b[B1_REMOTE_OV]   = c.remote_a_overvoltage | c.remote_b_overvoltage;   // [RULE17]
                b[B1_LOCAL_OV]    = c.local_overvoltage;                               // [RULE17]
            end
            2: begin
                b[B2_OVER_TEMP]   = c.over_temperature;                                // [RULE18]
                b[B2_FAST_OV]     = c.fast_overvoltage;
                b[B2_SHARE]       = c.share_out_of_window;                             // [RULE19]
                b[B2_CONST_CURR]  = c.constant_current;
                b[B2_SOFT_START]  = c.soft_start_ramp;                                 // [RULE20]
                b[B2_LINE_IMP]    = c.line_impedance_high;
                b[B2_SS_FILTER]   = c.soft_start_filter;
                b[B2_EXT_FAULT]   = c.external_fault_input;                            // [RULE21]
            end
            default: begin
                b[B3_VSB_LIMIT]   = c.vsb_at_max | c.vsb_at_min;                       // [RULE1]
                b[B3_MOD_CLAMP]   = c.mod_at_upper | c.mod_at_lower;                   // [RULE2]
                b[B3_LIGHT_LOAD]  = c.light_load;                                      // [RULE3]
                b[B3_DEAD_TIME]   = c.dead_time_active;                                // [RULE4]
                b[B3_AC_SENSE]    = c.ac_sense_input_bad;                              // [RULE5]
                b[B3_NVM_CRC]     = c.nvm_crc_fail;                                    // [RULE6]
                b[B3_NVM_UNLOCK]  = c.nvm_unlocked;                                    // [RULE7]
                b                 = b & REG3_MASK;                                     // [RULE24]
            end
        endcase
        return b;
    endfunction

    ffsb_byte_t live_r  [FFSB_NREG];
    ffsb_byte_t latch_r [FFSB_NREG];
    ffsb_byte_t live_nxt  [FFSB_NREG];
    ffsb_byte_t latch_nxt [FFSB_NREG];
    ffsb_byte_t clr_mask  [FFSB_NREG];
    ffsb_byte_t rdata_nxt;

    // clear strobes: one latched register by selector, or all of them by key
    wire        clr_sel_hit = WR && (ADDR == ADDR_CLR_SEL);
    wire        clr_all_hit = WR && (ADDR == ADDR_CLR_ALL) && (WDATA == CLR_ALL_VAL);
    wire  [1:0] clr_sel_idx = WDATA[1:0];
    wire        live_hit    = (ADDR <= ADDR_LIVE3);
    wire        latch_hit   = (ADDR >= ADDR_LATCH0) && (ADDR <= ADDR_LATCH3);
    wire  [1:0] rd_idx      = ADDR[1:0];

    genvar gi;
    generate
        for (gi = 0; gi < FFSB_NREG; gi++) begin : g_reg
            // a selected clear empties the whole latched register, not single bits
            assign clr_mask[gi] = clr_all_hit ? '1
                                : (clr_sel_hit && (clr_sel_idx == 2'(gi))) ? '1
                                : '0;
            assign live_nxt[gi] = build_live(COND, gi);
            // a set arriving with the clear wins, so no event is lost
            assign latch_nxt[gi] = ((latch_r[gi] & ~clr_mask[gi]) | live_nxt[gi])
                                 & ((gi == FFSB_NREG - 1) ? REG3_MASK : 8'hff); // [RULE22] [RULE23] [RULE24]

            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    live_r[gi]  <= FLAG_RST;
                    latch_r[gi] <= FLAG_RST;
                end else begin
                    live_r[gi]  <= live_nxt[gi];
                    latch_r[gi] <= latch_nxt[gi];
                end
            end
        end
    endgenerate

    // writes to flag registers themselves are ignored: they are read-only
    assign rdata_nxt = !RD      ? RD_UNMAPPED
                     : live_hit  ? live_r[rd_idx]
                     : latch_hit ? latch_r[rd_idx]
                     : RD_UNMAPPED;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RDATA <= FLAG_RST;
        end else begin
            RDATA <= rdata_nxt;
        end
    end

    assign ANY_LATCHED = |{latch_r[0], latch_r[1], latch_r[2], latch_r[3]};

    // assertions
    logic past_valid_r;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            past_valid_r <= 1'b0;
        end else begin
            past_valid_r <= 1'b1;
        end
    end

    default clocking ffsb_cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    // a condition seen on one edge shows in the live flag on the next
    sequence s_cond_seen(logic c);
        c ##1 1'b1;
    endsequence

    // no clear of any kind reaches the latched set this cycle
    sequence s_no_clear;
        !clr_all_hit && !clr_sel_hit;
    endsequence

    vsb_flag_a: assert property ( // [RULE1]
        s_cond_seen(COND.vsb_at_max | COND.vsb_at_min)
            |-> live_r[3][B3_VSB_LIMIT])
        else $error("volt-second flag missing");

    mod_clamp_a: assert property ( // [RULE2]
        past_valid_r |-> live_r[3][B3_MOD_CLAMP]
            == ($past(COND.mod_at_upper) | $past(COND.mod_at_lower)))
        else $error("modulation flag wrong");

    light_load_a: assert property ( // [RULE3]
        past_valid_r
            |-> live_r[3][B3_LIGHT_LOAD] == $past(COND.light_load))
        else $error("light-load flag wrong");

    dead_time_a: assert property ( // [RULE4]
        past_valid_r
            |-> live_r[3][B3_DEAD_TIME] == $past(COND.dead_time_active))
        else $error("dead-time flag wrong");

    ac_sense_a: assert property ( // [RULE5]
        past_valid_r
            |-> live_r[3][B3_AC_SENSE] == $past(COND.ac_sense_input_bad))
        else $error("ac sense flag wrong");

    crc_live_a: assert property ( // [RULE6]
        past_valid_r
            |-> live_r[3][B3_NVM_CRC] == $past(COND.nvm_crc_fail))
        else $error("checksum flag wrong");

    nvm_unlock_a: assert property ( // [RULE7]
        past_valid_r
            |-> live_r[3][B3_NVM_UNLOCK] == $past(COND.nvm_unlocked))
        else $error("unlock flag wrong");

    supply_off_a: assert property ( // [RULE8]
        past_valid_r
            |-> live_r[0][B0_SUPPLY_OFF] == $past(COND.supply_off))
        else $error("supply off flag wrong");

    iso_gate_a: assert property ( // [RULE9]
        past_valid_r
            |-> live_r[0][B0_ISO_OFF] == $past(COND.isolation_switch_gate_off))
        else $error("isolation gate flag wrong");

    rect_off_a: assert property ( // [RULE10]
        (COND.rectifier_drive_a_off && !COND.rectifier_drive_b_off)
            |=> !live_r[0][B0_RECT_OFF])
        else $error("rectifier flag set with one drive on");

    rect_both_a: assert property ( // [RULE10]
        (COND.rectifier_drive_a_off && COND.rectifier_drive_b_off)
            |=> live_r[0][B0_RECT_OFF])
        else $error("rectifier flag missing");

    fast_oc_a: assert property ( // [RULE11]
        past_valid_r
            |-> live_r[0][B0_PRI_FAST_OC] == $past(COND.primary_fast_oc))
        else $error("fast overcurrent flag wrong");

    accurate_oc_a: assert property ( // [RULE12]
        past_valid_r |-> {live_r[0][B0_PRI_ACC_OC], live_r[0][B0_SEC_ACC_OC]}
            == $past({COND.primary_accurate_oc, COND.secondary_accurate_oc}))
        else $error("accurate overcurrent flags wrong");

    continuity_a: assert property ( // [RULE13]
        past_valid_r |-> live_r[1][B1_CONTINUITY] == $past(COND.continuity_local_remote_bad
            | COND.continuity_remote_pair_bad))
        else $error("continuity flag wrong");

    local_uv_a: assert property ( // [RULE14]
        past_valid_r
            |-> live_r[1][B1_LOCAL_UV] == $past(COND.local_undervoltage))
        else $error("local undervoltage flag wrong");

    iso_reverse_a: assert property ( // [RULE15]
        past_valid_r
            |-> live_r[1][B1_ISO_REVERSE] == $past(COND.isolation_switch_reverse))
        else $error("reverse voltage flag wrong");

    core_ov_a: assert property ( // [RULE16]
        past_valid_r
            |-> live_r[1][B1_CORE_OV] == $past(COND.core_supply_overvoltage))
        else $error("core overvoltage flag wrong");

    remote_ov_a: assert property ( // [RULE17]
        COND.remote_b_overvoltage
            |=> live_r[1][B1_REMOTE_OV])
        else $error("remote overvoltage not flagged");

    local_ov_a: assert property ( // [RULE17]
        past_valid_r
            |-> live_r[1][B1_LOCAL_OV] == $past(COND.local_overvoltage))
        else $error("local overvoltage flag wrong");

    over_temp_a: assert property ( // [RULE18]
        past_valid_r
            |-> live_r[2][B2_OVER_TEMP] == $past(COND.over_temperature))
        else $error("overtemperature flag wrong");

    share_window_a: assert property ( // [RULE19]
        past_valid_r
            |-> live_r[2][B2_SHARE] == $past(COND.share_out_of_window))
        else $error("share flag wrong");

    soft_start_a: assert property ( // [RULE20]
        past_valid_r
            |-> live_r[2][B2_SOFT_START] == $past(COND.soft_start_ramp))
        else $error("soft-start flag wrong");

    ext_fault_a: assert property ( // [RULE21]
        COND.external_fault_input
            |=> live_r[2][B2_EXT_FAULT] && latch_r[2][B2_EXT_FAULT])
        else $error("external fault not flagged");

    // latched set: every live bit is also held there, since set beats clear
    latch_mirror_a: assert property ( // [RULE22]
        past_valid_r
            |-> ((live_r[1] & ~latch_r[1]) == '0))
        else $error("live bit set but latched copy clear");

    latch_cover_a: assert property ( // [RULE22]
        past_valid_r |-> (((live_r[0] & ~latch_r[0]) | (live_r[2] & ~latch_r[2])
            | (live_r[3] & ~latch_r[3])) == '0))
        else $error("latched copy misses a live bit");

    latch_sticky_a: assert property ( // [RULE23]
        (latch_r[0][B0_SUPPLY_OFF] && !clr_sel_hit && !clr_all_hit)
            |=> latch_r[0][B0_SUPPLY_OFF])
        else $error("latched flag dropped without clear");

    latch_clear_a: assert property ( // [RULE23]
        (clr_all_hit && !COND.over_temperature)
            |=> !latch_r[2][B2_OVER_TEMP])
        else $error("latched flag survived clear");

    clear_sel_a: assert property ( // [RULE23]
        (clr_sel_hit && clr_sel_idx == 2'h1 && live_nxt[1] == '0)
            |=> latch_r[1] == '0)
        else $error("selected clear left bits behind");

    key_refused_a: assert property ( // [RULE23]
        (WR && ADDR == ADDR_CLR_ALL && WDATA != CLR_ALL_VAL && latch_r[0][B0_SUPPLY_OFF])
            |=> latch_r[0][B0_SUPPLY_OFF])
        else $error("clear without key took effect");

    crc_flag_a: assert property ( // [RULE6]
        COND.nvm_crc_fail ##1 s_no_clear [*2]
            |-> latch_r[3][B3_NVM_CRC])
        else $error("checksum latched flag lost");

    set_wins_a: assert property ( // [RULE23]
        (clr_all_hit && COND.supply_off)
            |=> latch_r[0][B0_SUPPLY_OFF])
        else $error("clear beat a new event");

    any_latched_a: assert property ( // [RULE23]
        (latch_r[2][B2_OVER_TEMP] || latch_r[3][B3_NVM_UNLOCK])
            |-> ANY_LATCHED)
        else $error("latched summary low with a flag held");

    reserved_zero_a: assert property ( // [RULE24]
        ((live_r[3] | latch_r[3]) & ~REG3_MASK)
            == '0)
        else $error("reserved bit set");

    read_data_a: assert property ( // [RULE18]
        (RD && ADDR == ADDR_LIVE2)
            |=> RDATA == $past(live_r[2]))
        else $error("read data mismatch");

    read_latch_a: assert property ( // [RULE22]
        (RD && ADDR == ADDR_LATCH0)
            |=> RDATA == $past(latch_r[0]))
        else $error("latched read data mismatch");

endmodule // ffsb_flag_bank

// file: tb/ffsb_flag_bank_tb.sv
// ffsb_flag_bank_tb: register-level bench for the live and latched fault flag bank
// assumes the one-cycle strobe port, read data one cycle after the read strobe
`timescale 1ns/1ps

module ffsb_flag_bank_tb
    import ffsb_pkg::*;
;
    logic               ref_clk;
    logic               rst;
    ffsb_cond_s         cond;
    logic [FFSB_AW-1:0] addr;
    ffsb_byte_t         wdata;
    logic               wr;
    logic               rd;
    logic [FFSB_DW-1:0] rdata;
    logic               any_latched;
    int                 miscompares;
    int                 num_checks;
    int                 cycles;
    // per condition field, msb first: {reg, bit}, ff = no flag on its own
    localparam logic [7:0] MAP [36] = '{
        8'h07, 8'h06, 8'h05, 8'h04, 8'hff, 8'hff, 8'h02, 8'h01, 8'h00,
        8'h17, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h11, 8'h10,
        8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21, 8'h20,
        8'h37, 8'h37, 8'h36, 8'h36, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30};

    ffsb_flag_bank i_ffsb_flag_bank (
        .REF_CLK     (ref_clk),
        .RST         (rst),
        .COND        (cond),
        .ADDR        (addr),
        .WDATA       (wdata),
        .WR          (wr),
        .RD          (rd),
        .RDATA       (rdata),
        .ANY_LATCHED (any_latched)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic results();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a hang would otherwise end without a verdict
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            results();
        end
    end

    task automatic check(input string name, input ffsb_byte_t seen, input ffsb_byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input ffsb_byte_t d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    // one idle cycle between reads keeps the answer cycle unambiguous
    task automatic rd_reg(input logic [3:0] a, input ffsb_byte_t exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        check($sformatf("reg %h", a), rdata, exp);
    endtask

    function automatic ffsb_byte_t exp_of(input int i, input int r);
        logic [7:0] m;
        m = MAP[i];
        if (m != 8'hff && m[5:4] == r[1:0]) begin
            return 8'h01 << m[2:0];
        end
        return 8'h00;
    endfunction

    task automatic settle(input ffsb_cond_s c);
        @(posedge ref_clk);
        cond <= c;
        repeat (2) @(posedge ref_clk);
    endtask

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        cond = '0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check("any_latched", {7'h00, any_latched}, 8'h00);
        for (int r = 0; r < 8; r++) rd_reg(ADDR_LIVE0 + 4'(r), FLAG_RST);
        for (int i = 0; i < 36; i++) begin
            settle(ffsb_cond_s'(36'h8_0000_0000 >> i));
            for (int r = 0; r < 4; r++) rd_reg(ADDR_LIVE0 + 4'(r), exp_of(i, r));
            settle('0);
            for (int r = 0; r < 4; r++) rd_reg(ADDR_LIVE0 + 4'(r), 8'h00);
            for (int r = 0; r < 4; r++) rd_reg(ADDR_LATCH0 + 4'(r), exp_of(i, r));
            check("any_latched", {7'h00, any_latched}, {7'h00, MAP[i] != 8'hff});
            wr_reg(ADDR_CLR_ALL, CLR_ALL_VAL);
            for (int r = 0; r < 4; r++) rd_reg(ADDR_LATCH0 + 4'(r), 8'h00);
        end
        // both rectifier drives off together
        @(posedge ref_clk);
        cond.rectifier_drive_a_off <= 1'b1;
        cond.rectifier_drive_b_off <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd_reg(ADDR_LIVE0, 8'h08);
        // every condition present; reserved bit stays low and ignores writes
        settle('1);
        wr_reg(ADDR_LIVE3, 8'hff);
        wr_reg(ADDR_LATCH3, 8'hff);
        for (int r = 0; r < 3; r++) rd_reg(ADDR_LIVE0 + 4'(r), 8'hff);
        rd_reg(ADDR_LIVE3, REG3_MASK);
        rd_reg(ADDR_LATCH3, REG3_MASK);
        settle('0);
        wr_reg(ADDR_CLR_ALL, 8'h5a);
        rd_reg(ADDR_LATCH0, 8'hff);
        wr_reg(ADDR_CLR_SEL, 8'h01);
        rd_reg(ADDR_LATCH0 + 4'h1, 8'h00);
        rd_reg(ADDR_LATCH0 + 4'h2, 8'hff);
        rd_reg(ADDR_LATCH3, REG3_MASK);
        @(posedge ref_clk);
        #1;
        check("rdata idle", rdata, 8'h00);
        rd_reg(4'ha, RD_UNMAPPED);
        // a clear while the condition is still present must not lose it
        wr_reg(ADDR_CLR_ALL, CLR_ALL_VAL);
        settle(ffsb_cond_s'(36'h8_0000_0000));
        wr_reg(ADDR_CLR_ALL, CLR_ALL_VAL);
        rd_reg(ADDR_LATCH0, 8'h80);
        settle('0);
        wr_reg(ADDR_CLR_ALL, CLR_ALL_VAL);
        @(posedge ref_clk);
        #1;
        check("any_latched", {7'h00, any_latched}, 8'h00);
        results();
    end
endmodule // ffsb_flag_bank_tb
